// >>> include/acc_pkg.sv
package acc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned NUM_UNITS    = 3;
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFF_CTRL0    = 8'h00;
  localparam logic [7:0]  OFF_CTRL1    = 8'h04;
  localparam logic [7:0]  OFF_CTRL2    = 8'h08;
  localparam logic [7:0]  OFF_STAT     = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h14;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int unsigned CTRL_ENABLE  = 15;
  localparam int unsigned CTRL_PIN_EN  = 14;
  localparam int unsigned CTRL_INVERT  = 13;
  localparam int unsigned CTRL_RESULT  = 8;
  localparam int unsigned CTRL_EDGE_HI = 7;
  localparam int unsigned CTRL_EDGE_LO = 6;
  localparam int unsigned CTRL_POS_SEL = 4;
  localparam int unsigned CTRL_NEG_HI  = 1;
  localparam int unsigned CTRL_NEG_LO  = 0;
  localparam logic [31:0] CTRL_WMASK   = 32'h0000_E0D3;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_00C3;

  // ****************************************
  // Shared status fields
  // ****************************************
  localparam int unsigned STAT_IDLE_STOP = 13;
  localparam logic [31:0] STAT_WMASK     = 32'h0000_2000;
  localparam logic [31:0] STAT_RESET     = 32'h0000_0000;

  typedef enum logic [1:0] {
    ACC_EDGE_NONE = 2'b00,
    ACC_EDGE_RISE = 2'b01,
    ACC_EDGE_FALL = 2'b10,
    ACC_EDGE_BOTH = 2'b11
  } acc_edge_t;

  typedef enum logic [1:0] {
    ACC_NEG_B    = 2'b00,
    ACC_NEG_C    = 2'b01,
    ACC_NEG_D    = 2'b10,
    ACC_NEG_IREF = 2'b11
  } acc_neg_t;

  typedef struct packed {
    logic            enable;
    logic            output_pin_enable;
    logic            output_invert;
    acc_edge_t       event_edge_select;
    logic            positive_input_select;
    acc_neg_t        negative_input_select;
  } acc_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } acc_bus_req_t;

endpackage

// >>> src/acc_top.sv
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Operation
// - Unit runs only while enabled; an enable write also loads all other writable fields from the write data
// - Output-pin enable drives result onto the unit's result pin
// - Inversion bit complements the raw comparison result
// - Read-only result bit shows current unit output level
// - Edge field: 00 none, 01 rising, 10 falling, 11 both
// - Inversion also feeds the event generator, flipping the edge
// - Positive select: ladder reference when one, input A pin when zero
// - Negative select: 00 B, 01 C, 10 D, 11 fixed internal reference
// - Unimplemented control bits read zero and ignore writes
// - Three identical independently configured comparator units
// - Disabled unit powers down yet keeps configuration accessible
// - Stop-in-idle halts all units while device idles
// - Shared status mirrors unit results in bits 2..0
module acc_top
  import acc_pkg::*;
#(
  parameter int unsigned UNITS = 3
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire acc_pkg::acc_bus_req_t bus_req,
  output logic [31:0]               rdata,
  input  wire logic                 device_idle,
  input  wire logic [UNITS-1:0]     cmp_raw,
  output logic [UNITS-1:0]          unit_power_en,
  output logic [UNITS-1:0]          pos_ladder_sel,
  output logic [2*UNITS-1:0]        neg_input_sel,
  output logic [UNITS-1:0]          result_pin,
  output logic [UNITS-1:0]          result_pin_oe,
  output logic [UNITS-1:0]          event_pulse,
  output logic                      irq
);
  import acc_pkg::*;

  if (UNITS != NUM_UNITS) begin : g_bad_units
    $error("acc_top serves exactly three comparator units");
  end

  // ****************************************
  // Register storage
  // ****************************************
  logic [31:0]       ctrl_q [UNITS];
  logic [31:0]       stat_cfg_q;
  logic [UNITS-1:0]  irq_stat_q;
  logic [UNITS-1:0]  irq_mask_q;
  logic [UNITS-1:0]  sync1_q;
  logic [UNITS-1:0]  sync2_q;
  logic [UNITS-1:0]  prev_q;
  logic [UNITS-1:0]  result_q;
  logic [UNITS-1:0]  run;
  logic [UNITS-1:0]  level;
  logic [UNITS-1:0]  evt;
  logic              idle_sync1_q;
  logic              idle_sync2_q;
  logic [UNITS-1:0]  w1c;
  logic [UNITS-1:0]  run_q;
  logic [UNITS-1:0]  irq_stat_d;
  logic [UNITS-1:0]  irq_mask_d;

  assign w1c = (bus_req.wr && bus_req.addr == OFF_IRQ_STAT) ? bus_req.wdata[UNITS-1:0]
                                                            : '0;
  // New event wins over a clear in the same cycle
  assign irq_stat_d = (irq_stat_q & ~w1c) | event_pulse;
  assign irq_mask_d = (bus_req.wr && bus_req.addr == OFF_IRQ_MASK) ? bus_req.wdata[UNITS-1:0]
                                                                   : irq_mask_q;

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q      <= '0;
      sync2_q      <= '0;
      idle_sync1_q <= 1'b0;
      idle_sync2_q <= 1'b0;
    end else begin
      sync1_q      <= cmp_raw;
      sync2_q      <= sync1_q;
      idle_sync1_q <= device_idle;
      idle_sync2_q <= idle_sync1_q;
    end
  end

  // ****************************************
  // Per-unit logic
  // ****************************************
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    logic       inv;
    acc_edge_t  edge_sel;
    assign inv      = ctrl_q[u][CTRL_INVERT];
    assign edge_sel = acc_edge_t'(ctrl_q[u][CTRL_EDGE_HI:CTRL_EDGE_LO]);
    assign run[u]   = ctrl_q[u][CTRL_ENABLE] && !(stat_cfg_q[STAT_IDLE_STOP] && idle_sync2_q);
    assign level[u] = run[u] & (sync2_q[u] ^ inv);
    always_comb begin
      unique case (edge_sel)
        ACC_EDGE_NONE: evt[u] = 1'b0;
        ACC_EDGE_RISE: evt[u] = level[u] & ~prev_q[u];
        ACC_EDGE_FALL: evt[u] = ~level[u] & prev_q[u];
        ACC_EDGE_BOTH: evt[u] = level[u] ^ prev_q[u];
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_q      <= '0;
      result_q    <= '0;
      event_pulse <= '0;
    end else begin
      prev_q      <= level;
      result_q    <= level;
      event_pulse <= evt & run & run_q;
    end
  end

  // Avoid a spurious edge on the cycle a unit starts
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= '0;
    end else begin
      run_q <= run;
    end
  end

  // ****************************************
  // Analog steering and pin drive
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      unit_power_en  <= '0;
      pos_ladder_sel <= '0;
      neg_input_sel  <= '0;
      result_pin     <= '0;
      result_pin_oe  <= '0;
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        unit_power_en[u]      <= run[u];
        pos_ladder_sel[u]     <= ctrl_q[u][CTRL_POS_SEL];
        neg_input_sel[2*u +: 2] <= ctrl_q[u][CTRL_NEG_HI:CTRL_NEG_LO];
        result_pin_oe[u]      <= ctrl_q[u][CTRL_PIN_EN];
        result_pin[u]         <= ctrl_q[u][CTRL_PIN_EN] & level[u];
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // write mask
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int u = 0; u < UNITS; u++) begin
        ctrl_q[u] <= CTRL_RESET;
      end
      stat_cfg_q <= STAT_RESET;
      irq_mask_q <= '0;
    end else if (bus_req.wr) begin
      for (int u = 0; u < UNITS; u++) begin
        if (bus_req.addr == ADDR_W'(4 * u)) begin
          ctrl_q[u] <= bus_req.wdata & CTRL_WMASK;
        end
      end
      if (bus_req.addr == OFF_STAT) begin
        stat_cfg_q <= bus_req.wdata & STAT_WMASK;
      end
      if (bus_req.addr == OFF_IRQ_MASK) begin
        irq_mask_q <= bus_req.wdata[UNITS-1:0];
      end
    end
  end

  // ****************************************
  // Sticky interrupt status
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq        <= |(irq_stat_d & irq_mask_d);
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (bus_req.rd) begin
      rdata <= '0;
      for (int u = 0; u < UNITS; u++) begin
        if (bus_req.addr == ADDR_W'(4 * u)) begin
          rdata <= ctrl_q[u] | (32'(result_q[u]) << CTRL_RESULT);
        end
      end
      if (bus_req.addr == OFF_STAT) begin
        rdata <= stat_cfg_q | 32'(result_q);
      end
      if (bus_req.addr == OFF_IRQ_STAT) begin
        rdata <= 32'(irq_stat_q);
      end
      if (bus_req.addr == OFF_IRQ_MASK) begin
        rdata <= 32'(irq_mask_q);
      end
    end else begin
      rdata <= '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_disabled_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    !ctrl_q[0][CTRL_ENABLE] |=> !result_q[0])
    else $error("disabled unit shows a result");

  a_pin_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    !ctrl_q[0][CTRL_PIN_EN] |=> !result_pin[0] && !result_pin_oe[0])
    else $error("result pin driven while disabled");

  a_invert_level: assert property (@(posedge core_clk) disable iff (!rstn)
    run[1] |=> result_q[1] == ($past(sync2_q[1]) ^ $past(ctrl_q[1][CTRL_INVERT])))
    else $error("result not raw xor invert");

  a_result_read: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == OFF_CTRL2 |=> rdata[CTRL_RESULT] == $past(result_q[2]))
    else $error("result bit readback wrong");

  a_edge_none: assert property (@(posedge core_clk) disable iff (!rstn)
    ctrl_q[0][CTRL_EDGE_HI:CTRL_EDGE_LO] == 2'b00 |=> !event_pulse[0])
    else $error("event with edges disabled");

  a_rise_event: assert property (@(posedge core_clk) disable iff (!rstn)
    run_q[0] && run[0] && ctrl_q[0][CTRL_EDGE_HI:CTRL_EDGE_LO] == 2'b01
      && !prev_q[0] && level[0] |=> event_pulse[0])
    else $error("rising event missed");

  a_pos_route: assert property (@(posedge core_clk) disable iff (!rstn)
    1'b1 |=> pos_ladder_sel[1] == $past(ctrl_q[1][CTRL_POS_SEL]))
    else $error("positive input route wrong");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == OFF_CTRL1 |=> (rdata & ~(CTRL_WMASK | 32'h0000_0100)) == '0)
    else $error("reserved bits read nonzero");

  a_idle_stop: assert property (@(posedge core_clk) disable iff (!rstn)
    stat_cfg_q[STAT_IDLE_STOP] && idle_sync2_q |=> unit_power_en == '0)
    else $error("units run in idle stop");

  a_pulse_single: assert property (@(posedge core_clk) disable iff (!rstn)
    event_pulse[2] && ctrl_q[2][CTRL_EDGE_HI:CTRL_EDGE_LO] != 2'b11 |=> !event_pulse[2])
    else $error("event pulse longer than a cycle");

  a_neg_route: assert property (@(posedge core_clk) disable iff (!rstn)
    1'b1 |=> neg_input_sel[5:4] == $past(ctrl_q[2][CTRL_NEG_HI:CTRL_NEG_LO]))
    else $error("negative input route wrong");

  a_pin_value: assert property (@(posedge core_clk) disable iff (!rstn)
    ctrl_q[1][CTRL_PIN_EN] |=> result_pin_oe[1] && result_pin[1] == $past(level[1]))
    else $error("result pin does not follow unit output");

  a_stat_mirror: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == OFF_STAT |=> rdata[UNITS-1:0] == $past(result_q))
    else $error("shared status result mirror wrong");

  a_power_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    !ctrl_q[1][CTRL_ENABLE] |=> !unit_power_en[1])
    else $error("disabled unit still powered");

  a_start_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    run[0] && !run_q[0] |=> !event_pulse[0])
    else $error("event on the cycle a unit starts");

  a_fall_invert: assert property (@(posedge core_clk) disable iff (!rstn)
    run[0] && $past(run[0]) && ctrl_q[0][CTRL_INVERT] && $past(ctrl_q[0][CTRL_INVERT])
      && ctrl_q[0][CTRL_EDGE_HI:CTRL_EDGE_LO] == 2'b10 && !$past(sync2_q[0]) && sync2_q[0]
      |=> event_pulse[0])
    else $error("inverted rise gave no falling event");

  a_set_wins: assert property (@(posedge core_clk) disable iff (!rstn)
    event_pulse[0] |=> irq_stat_q[0])
    else $error("event lost in sticky status");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
    irq == |(irq_stat_q & irq_mask_q))
    else $error("interrupt level does not match masked status");

  a_wmask_write: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_req.wr && bus_req.addr == OFF_CTRL0 |=> ctrl_q[0] == ($past(bus_req.wdata) & CTRL_WMASK))
    else $error("control write not masked");

endmodule

// >>> verification/acc_analog_model.sv
`timescale 1ns/1ps
module acc_analog_model (
  input  wire logic        core_clk,
  input  wire logic [2:0]  unit_power_en,
  input  wire logic [2:0]  pos_ladder_sel,
  input  wire logic [5:0]  neg_input_sel,
  input  wire logic [7:0]  ladder_lvl,
  input  wire logic [7:0]  fixed_lvl,
  input  wire logic [95:0] pin_lvl,
  output logic [2:0]       cmp_raw
);
  logic [7:0] pv;
  logic [7:0] nv;
  logic       tgl_q = 1'b0;

  // ****************************************
  // Analog front end
  // ****************************************
  always_ff @(posedge core_clk) tgl_q <= ~tgl_q;
  always_comb begin
    for (int u = 0; u < 3; u++) begin
      pv = pos_ladder_sel[u] ? ladder_lvl : pin_lvl[32*u +: 8];
      nv = (&neg_input_sel[2*u +: 2]) ? fixed_lvl
         : pin_lvl[32*u + 8 + 8*neg_input_sel[2*u +: 2] +: 8];
      cmp_raw[u] = unit_power_en[u] ? (pv > nv) : (tgl_q ^ u[0]);
    end
  end
endmodule

// >>> verification/acc_top_tb.sv
`timescale 1ns/1ps
module acc_top_tb;
  import acc_pkg::*;
  localparam logic [7:0] LADDER = 8'h80;
  localparam logic [7:0] FIXED  = 8'h40;
  logic         core_clk, rstn, device_idle, irq, r, f1;
  acc_bus_req_t bus_req;
  logic [31:0]  rdata, v, w;
  logic [31:0]  rng = 32'h0000_03AF;
  logic [2:0]   cmp_raw, pwr, pos, pin, oe, ev;
  logic [5:0]   neg;
  logic [3:0]   c;
  logic [7:0]   lv [12];
  logic [95:0]  pin_lvl;
  int           miscompares = 0, checked = 0, cyc = 0, u, ev_cnt [3];

  acc_top dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .device_idle(device_idle), .cmp_raw(cmp_raw), .unit_power_en(pwr),
    .pos_ladder_sel(pos), .neg_input_sel(neg), .result_pin(pin),
    .result_pin_oe(oe), .event_pulse(ev), .irq(irq));
  acc_analog_model pm (.core_clk(core_clk), .unit_power_en(pwr), .pos_ladder_sel(pos),
    .neg_input_sel(neg), .ladder_lvl(LADDER), .fixed_lvl(FIXED), .pin_lvl(pin_lvl),
    .cmp_raw(cmp_raw));
  always_comb for (int i = 0; i < 12; i++) pin_lvl[8*i +: 8] = lv[i];

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++) if (rstn === 1'b1 && ev[i] === 1'b1) ev_cnt[i]++;
    if (cyc == 8000) begin
      miscompares++;
      test_done;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic exp_raw(int n, logic p, logic [1:0] s);
    logic [7:0] a, b;
    a = p ? LADDER : lv[4*n];
    b = (s == 2'b11) ? FIXED : lv[4*n + s + 1];
    return a > b;
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    rstn = 1'b0;
    device_idle = 1'b0;
    bus_req = '0;
    lv = '{default: 8'h00};
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      rd(OFF_CTRL0 + 8'(4*k));
      chk("ctrl_reset", v, CTRL_RESET);
      w = xs() & 32'hFFFF_7FFF;
      wr(OFF_CTRL0 + 8'(4*k), w);
      rd(OFF_CTRL0 + 8'(4*k));
      chk("ctrl_mask", v, w & CTRL_WMASK);
      chk("power_off", pwr[k], 1'b0);
      wr(OFF_CTRL0 + 8'(4*k), w | 32'h8000);
      tick(2);
      rd(OFF_CTRL0 + 8'(4*k));
      chk("ctrl_keep", v & 32'hFFFF_FEFF, (w | 32'h8000) & CTRL_WMASK);
      chk("sel_out", {pwr[k], pos[k], neg[2*k +: 2]}, {1'b1, w[4], w[1:0]});
    end
    rd(OFF_STAT);
    chk("stat_reset", v & 32'hFFFF_FFF8, STAT_RESET);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18);
    chk("unmapped", v, 32'h0);
    for (int k = 0; k < 48; k++) begin
      u = k % 3;
      c = 4'(k / 3);
      @(posedge core_clk);
      for (int i = 0; i < 4; i++) lv[4*u + i] <= 8'(xs());
      w = 32'h8000 | (32'(c[1]) << 14) | (32'(c[3]) << 13) | (32'(c[2]) << 4) | 32'(c[1:0]);
      wr(OFF_CTRL0 + 8'(4*u), w);
      tick(8);
      r = exp_raw(u, c[2], c[1:0]) ^ c[3];
      rd(OFF_CTRL0 + 8'(4*u));
      chk("result_bit", v[8], r);
      rd(OFF_STAT);
      chk("stat_result", v[u], r);
      chk("pin", {pin[u], oe[u]}, c[1] ? {r, 1'b1} : 2'b00);
    end
    for (int e = 0; e < 8; e++) begin
      u = e % 3;
      @(posedge core_clk);
      lv[4*u] <= 8'h10;
      lv[4*u + 1] <= 8'h20;
      wr(OFF_CTRL0 + 8'(4*u), 32'h8000 | (32'(e[2]) << 13) | (32'(e[1:0]) << 6));
      wr(OFF_IRQ_MASK, 32'(e[2]) << u);
      tick(8);
      wr(OFF_IRQ_STAT, 32'h7);
      tick(2);
      ev_cnt[u] = 0;
      @(posedge core_clk);
      lv[4*u] <= 8'h30;
      tick(8);
      f1 = (e[1:0] == 2'b11) || (e[1:0] == {e[2], ~e[2]});
      chk("ev_first", 32'(ev_cnt[u]), 32'(f1));
      rd(OFF_IRQ_STAT);
      chk("irq_stat", v, 32'(f1) << u);
      chk("irq", irq, f1 & e[2]);
      @(posedge core_clk);
      lv[4*u] <= 8'h10;
      tick(8);
      chk("ev_total", 32'(ev_cnt[u]), (e[1:0] == 2'b11) ? 2 : 32'(e[1:0] != 0));
      wr(OFF_IRQ_STAT, 32'h7);
      tick(2);
      chk("irq_clear", irq, 1'b0);
    end
    @(posedge core_clk);
    lv[0] <= 8'h30;
    lv[1] <= 8'h10;
    wr(OFF_CTRL0, 32'h8000);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_STAT, 32'(s[0]) << 13);
      @(posedge core_clk);
      device_idle <= s[1];
      tick(8);
      rd(OFF_STAT);
      chk("idle_stop", {v[13], pwr[0], v[0]}, {s[0], ~(s[0] & s[1]), ~(s[0] & s[1])});
    end
    test_done;
  end
endmodule
